// ### inc/timer_pwm_map.svh
// Register map, field positions, reset values and mode codes of the timer/PWM block.
// Assumes a byte-wide register per aligned 32-bit word, reached over AXI4-Lite.
// What this block does
// - Edge/level select 00 frees the channel pin from all channel functions.
// - Mode 00 without center-align captures on rising, falling or either edge.
// - Mode 01 compares: flag only, toggle, clear or set the pin on match.
// - Mode 1X gives edge-aligned PWM, high-true for 10, low-true for X1.
// - Center-align makes all channels center PWM, acting on both up- and down-counting matches.
// - A pin unsteady one cycle before capture entry may give a false edge.
// - Each 16-bit channel value holds capture or compare value, reset to zero.
// - In capture, reading one value byte freezes both until the other is read.
// - In compare or PWM, value bytes buffer in any order, then move together.
// - Center-align makes the counter count up and down.
// - Clock source resets to none; 01 bus clock, others fixed clock or pin.
// - Counting pauses during debug halt and resumes afterwards.
// - Up-counting runs 0 to terminal count (ffff or modulus) and wraps.
// - Up/down counting turns at modulus and zero, each end lasting one tick.
// - The wrap interrupt is a level while wrap flag and its enable are set.
// - Up-counting sets the wrap flag on the step from terminal count to 0.
// - Up/down counting sets the wrap flag on turning down from the modulus.
// - Reading one count byte snapshots both until the other byte is read.
// - Writing either count byte zeroes the counter and drops the snapshot.
// - Channel flag clears by read-while-set then write 0; new events win.
// - Edge PWM: wrap drives the active level, match the inactive one.
// - Edge PWM loads a buffered value only when the counter reads zero.
`ifndef TIMER_PWM_MAP_SVH
`define TIMER_PWM_MAP_SVH
`define ADDR_TIMER_SC 8'h00
`define ADDR_COUNT_HI 8'h04
`define ADDR_COUNT_LO 8'h08
`define ADDR_MOD_HI 8'h0c
`define ADDR_MOD_LO 8'h10
`define CH_BASE 8'h14
`define CH_STRIDE 8'h0c
`define CH_OFF_SC 8'h00
`define CH_OFF_HI 8'h04
`define CH_OFF_LO 8'h08
`define FLAG_BIT 7
`define IE_BIT 6
`define CPWM_BIT 5
`define CLKS_HI 4
`define CLKS_LO 3
`define CH_MSB_BIT 5
`define CH_MSA_BIT 4
`define ELS_HI 3
`define ELS_LO 2
`define CLKS_NONE 2'h0
`define CLKS_BUS 2'h1
`define CLKS_FIXED 2'h2
`define ELS_OFF 2'h0
`define ELS_TOGGLE 2'h1
`define ELS_CLEAR 2'h2
`define ELS_SET 2'h3
`define COUNT_ZERO 16'h0000
`define COUNT_FULL 16'hffff
`define COUNT_ONE 16'h0001
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### inc/timer_pwm_pkg.sv
// Types shared by the timer/PWM block.
// Assumes the map header supplies all numeric constants.
package timer_pwm_pkg;

    typedef struct packed {
        logic flag;
        logic ie;
        logic msb;
        logic msa;
        logic [1:0] els;
    } chan_ctl_t;

    typedef struct packed {
        chan_ctl_t ctl;
        logic clr_arm;
        logic [15:0] value;
        logic [15:0] wbuf;
        logic hi_wr;
        logic lo_wr;
        logic [15:0] rsnap;
        logic rd_lat;
        logic rd_hi;
        logic pin_prev;
        logic pin_out;
    } chan_st_t;

    typedef struct packed {
        logic counter_wrap_flag;
        logic wrap_irq_enable;
        logic cpwm;
        logic [1:0] clks;
    } timer_ctl_t;

endpackage : timer_pwm_pkg

// ### src/timer_pwm.sv
// Timer/PWM block: 16-bit counter, modulus, and per-channel capture, compare and PWM.
// Assumes pins and clock enables are synchronous to ref_clk_i; registers on AXI4-Lite.
`timescale 1ns/1ns
`include "timer_pwm_map.svh"

module timer_pwm #(
    parameter int NUM_CH = 2
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Counter clock sources and debug
    input wire logic fixed_clk_en_i,
    input wire logic ext_clk_i,
    input wire logic debug_halt_i,
    // Channel pins
    input wire logic [NUM_CH-1:0] ch_pin_i,
    output logic [NUM_CH-1:0] ch_pin_o,
    output logic [NUM_CH-1:0] ch_pin_oe_o,
    // Interrupt requests
    output logic wrap_irq_o,
    output logic [NUM_CH-1:0] chan_irq_o,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    initial begin
        if (NUM_CH < 1 || NUM_CH > 8) begin
            $error("NUM_CH must lie between 1 and 8 to fit the address map.");
        end
    end

    typedef struct packed {
        timer_pwm_pkg::timer_ctl_t tsc;
        logic tof_arm;
        logic [15:0] cnt;
        logic dir_down;
        logic [15:0] cnt_snap;
        logic cnt_lat;
        logic cnt_rd_hi;
        logic [15:0] modulus;
        logic [15:0] mod_buf;
        logic mod_hi_wr;
        logic mod_lo_wr;
        logic ext_prev;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        timer_pwm_pkg::chan_st_t [NUM_CH-1:0] ch;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic aw_go;
    logic ar_go;
    logic tick;
    logic cnt_wr;
    logic wrap;
    logic [15:0] term;
    logic [NUM_CH-1:0] evt;
    logic [NUM_CH-1:0] detached;

    assign aw_go = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
    assign ar_go = s_axi_arvalid && !s_q.rvalid;
    assign s_axi_awready = aw_go;
    assign s_axi_wready = aw_go;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rdata = {24'h000000, s_q.rdata};
    assign wrap_irq_o = s_q.tsc.counter_wrap_flag && s_q.tsc.wrap_irq_enable;

    always_comb begin
        logic [7:0] cb;
        logic [7:0] wd;
        logic hit;
        logic rise;
        logic fall;
        logic match;
        logic cap;
        logic oc;
        logic epwm;
        logic [15:0] rv;
        cb = 8'h00;
        wd = s_axi_wdata[7:0];
        hit = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        match = 1'b0;
        cap = 1'b0;
        oc = 1'b0;
        epwm = 1'b0;
        rv = `COUNT_ZERO;
        s_d = s_q;
        cnt_wr = 1'b0;
        wrap = 1'b0;
        evt = '0;
        detached = '0;
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // Counter clock: the pin edge detector needs the pin held at least one bus cycle per level.
        s_d.ext_prev = ext_clk_i;
        unique case (s_q.tsc.clks)
            `CLKS_NONE: tick = 1'b0;
            `CLKS_BUS: tick = 1'b1;
            `CLKS_FIXED: tick = fixed_clk_en_i;
            default: tick = ext_clk_i && !s_q.ext_prev;
        endcase
        tick = tick && !debug_halt_i;
        term = (s_q.modulus == `COUNT_ZERO) ? `COUNT_FULL : s_q.modulus;

        // Register writes.
        if (aw_go) begin
            s_d.bvalid = 1'b1;
            if (s_axi_awaddr == `ADDR_TIMER_SC) begin
                hit = 1'b1;
                if (s_axi_wstrb[0]) begin
                    s_d.tsc.wrap_irq_enable = wd[`IE_BIT];
                    s_d.tsc.cpwm = wd[`CPWM_BIT];
                    s_d.tsc.clks = wd[`CLKS_HI:`CLKS_LO];
                    if (!wd[`FLAG_BIT] && s_q.tof_arm) begin
                        s_d.tsc.counter_wrap_flag = 1'b0;
                    end
                    s_d.tof_arm = 1'b0;
                    s_d.mod_hi_wr = 1'b0;
                    s_d.mod_lo_wr = 1'b0;
                end
            end
            if (s_axi_awaddr == `ADDR_COUNT_HI || s_axi_awaddr == `ADDR_COUNT_LO) begin
                hit = 1'b1;
                if (s_axi_wstrb[0]) begin
                    cnt_wr = 1'b1;
                end
            end
            if (s_axi_awaddr == `ADDR_MOD_HI) begin
                hit = 1'b1;
                if (s_axi_wstrb[0]) begin
                    s_d.mod_buf[15:8] = wd;
                    s_d.mod_hi_wr = 1'b1;
                end
            end
            if (s_axi_awaddr == `ADDR_MOD_LO) begin
                hit = 1'b1;
                if (s_axi_wstrb[0]) begin
                    s_d.mod_buf[7:0] = wd;
                    s_d.mod_lo_wr = 1'b1;
                end
            end
            for (int i = 0; i < NUM_CH; i++) begin
                cb = 8'(`CH_BASE + i * `CH_STRIDE);
                if (s_axi_awaddr == cb + `CH_OFF_SC) begin
                    hit = 1'b1;
                    if (s_axi_wstrb[0]) begin
                        s_d.ch[i].ctl.ie = wd[`IE_BIT];
                        s_d.ch[i].ctl.msb = wd[`CH_MSB_BIT];
                        s_d.ch[i].ctl.msa = wd[`CH_MSA_BIT];
                        s_d.ch[i].ctl.els = wd[`ELS_HI:`ELS_LO];
                        if (!wd[`FLAG_BIT] && s_q.ch[i].clr_arm) begin
                            s_d.ch[i].ctl.flag = 1'b0;
                        end
                        s_d.ch[i].clr_arm = 1'b0;
                        s_d.ch[i].rd_lat = 1'b0;
                        s_d.ch[i].hi_wr = 1'b0;
                        s_d.ch[i].lo_wr = 1'b0;
                    end
                end
                if (s_axi_awaddr == cb + `CH_OFF_HI) begin
                    hit = 1'b1;
                    if (s_axi_wstrb[0]) begin
                        s_d.ch[i].wbuf[15:8] = wd;
                        s_d.ch[i].hi_wr = 1'b1;
                    end
                end
                if (s_axi_awaddr == cb + `CH_OFF_LO) begin
                    hit = 1'b1;
                    if (s_axi_wstrb[0]) begin
                        s_d.ch[i].wbuf[7:0] = wd;
                        s_d.ch[i].lo_wr = 1'b1;
                    end
                end
            end
            s_d.bresp = hit ? `RESP_OKAY : `RESP_SLVERR;
        end

        // Register reads, with their snapshot and flag-arming side effects.
        if (ar_go) begin
            hit = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rdata = 8'h00;
            if (s_axi_araddr == `ADDR_TIMER_SC) begin
                hit = 1'b1;
                s_d.rdata = {s_q.tsc.counter_wrap_flag, s_q.tsc.wrap_irq_enable, s_q.tsc.cpwm, s_q.tsc.clks, 3'h0};
                s_d.tof_arm = s_q.tsc.counter_wrap_flag;
            end
            if (s_axi_araddr == `ADDR_COUNT_HI || s_axi_araddr == `ADDR_COUNT_LO) begin
                hit = 1'b1;
                rv = s_q.cnt_lat ? s_q.cnt_snap : s_q.cnt;
                if (!s_q.cnt_lat) begin
                    s_d.cnt_snap = s_q.cnt;
                    s_d.cnt_lat = 1'b1;
                    s_d.cnt_rd_hi = (s_axi_araddr == `ADDR_COUNT_HI);
                end else if (s_q.cnt_rd_hi != (s_axi_araddr == `ADDR_COUNT_HI)) begin
                    s_d.cnt_lat = 1'b0;
                end
                s_d.rdata = (s_axi_araddr == `ADDR_COUNT_HI) ? rv[15:8] : rv[7:0];
            end
            if (s_axi_araddr == `ADDR_MOD_HI || s_axi_araddr == `ADDR_MOD_LO) begin
                hit = 1'b1;
                s_d.rdata = (s_axi_araddr == `ADDR_MOD_HI) ? s_q.modulus[15:8] : s_q.modulus[7:0];
            end
            for (int i = 0; i < NUM_CH; i++) begin
                cb = 8'(`CH_BASE + i * `CH_STRIDE);
                if (s_axi_araddr == cb + `CH_OFF_SC) begin
                    hit = 1'b1;
                    s_d.rdata = {s_q.ch[i].ctl, 2'h0};
                    s_d.ch[i].clr_arm = s_q.ch[i].ctl.flag;
                end
                if (s_axi_araddr == cb + `CH_OFF_HI || s_axi_araddr == cb + `CH_OFF_LO) begin
                    hit = 1'b1;
                    rv = s_q.ch[i].value;
                    if (!s_q.tsc.cpwm && !s_q.ch[i].ctl.msb && !s_q.ch[i].ctl.msa) begin
                        rv = s_q.ch[i].rd_lat ? s_q.ch[i].rsnap : s_q.ch[i].value;
                        if (!s_q.ch[i].rd_lat) begin
                            s_d.ch[i].rsnap = s_q.ch[i].value;
                            s_d.ch[i].rd_lat = 1'b1;
                            s_d.ch[i].rd_hi = (s_axi_araddr == cb + `CH_OFF_HI);
                        end else if (s_q.ch[i].rd_hi != (s_axi_araddr == cb + `CH_OFF_HI)) begin
                            s_d.ch[i].rd_lat = 1'b0;
                        end
                    end
                    s_d.rdata = (s_axi_araddr == cb + `CH_OFF_HI) ? rv[15:8] : rv[7:0];
                end
            end
            s_d.rresp = hit ? `RESP_OKAY : `RESP_SLVERR;
        end

        // Main counter.
        if (cnt_wr) begin
            s_d.cnt = `COUNT_ZERO;
            s_d.dir_down = 1'b0;
            s_d.cnt_lat = 1'b0;
        end else if (tick && !s_q.tsc.cpwm) begin
            s_d.dir_down = 1'b0;
            if (s_q.cnt == term) begin
                s_d.cnt = `COUNT_ZERO;
                wrap = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + `COUNT_ONE;
            end
        end else if (tick) begin
            if (!s_q.dir_down) begin
                if (s_q.cnt >= s_q.modulus) begin
                    s_d.dir_down = 1'b1;
                    s_d.cnt = s_q.cnt - `COUNT_ONE;
                    wrap = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + `COUNT_ONE;
                end
            end else if (s_q.cnt == `COUNT_ZERO) begin
                s_d.dir_down = 1'b0;
                s_d.cnt = `COUNT_ONE;
            end else begin
                s_d.cnt = s_q.cnt - `COUNT_ONE;
            end
        end
        if (s_d.mod_hi_wr && s_d.mod_lo_wr && (!s_q.tsc.cpwm || wrap)) begin
            s_d.modulus = s_d.mod_buf;
            s_d.mod_hi_wr = 1'b0;
            s_d.mod_lo_wr = 1'b0;
        end
        if (wrap) begin
            s_d.tsc.counter_wrap_flag = 1'b1;
            s_d.tof_arm = 1'b0;
        end

        // Channels.
        for (int i = 0; i < NUM_CH; i++) begin
            s_d.ch[i].pin_prev = ch_pin_i[i];
            rise = ch_pin_i[i] && !s_q.ch[i].pin_prev;
            fall = !ch_pin_i[i] && s_q.ch[i].pin_prev;
            detached[i] = (s_q.ch[i].ctl.els == `ELS_OFF);
            cap = !s_q.tsc.cpwm && !s_q.ch[i].ctl.msb && !s_q.ch[i].ctl.msa;
            oc = !s_q.tsc.cpwm && !s_q.ch[i].ctl.msb && s_q.ch[i].ctl.msa;
            epwm = !s_q.tsc.cpwm && s_q.ch[i].ctl.msb;
            match = tick && !cnt_wr && (s_d.cnt == s_q.ch[i].value);
            if (cap) begin
                if ((s_q.ch[i].ctl.els[0] && rise) || (s_q.ch[i].ctl.els[1] && fall)) begin
                    s_d.ch[i].value = s_q.cnt;
                    evt[i] = 1'b1;
                end
            end else if (oc) begin
                evt[i] = match;
                if (match) begin
                    unique case (s_q.ch[i].ctl.els)
                        `ELS_OFF: s_d.ch[i].pin_out = s_q.ch[i].pin_out;
                        `ELS_TOGGLE: s_d.ch[i].pin_out = !s_q.ch[i].pin_out;
                        `ELS_CLEAR: s_d.ch[i].pin_out = 1'b0;
                        `ELS_SET: s_d.ch[i].pin_out = 1'b1;
                    endcase
                end
            end else if (epwm) begin
                evt[i] = match;
                if (tick && !cnt_wr && s_d.cnt == `COUNT_ZERO) begin
                    s_d.ch[i].pin_out = !s_q.ch[i].ctl.els[0];
                end
                if (match) begin
                    s_d.ch[i].pin_out = s_q.ch[i].ctl.els[0];
                end
            end else begin
                evt[i] = match;
                if (match) begin
                    s_d.ch[i].pin_out = s_q.dir_down ? !s_q.ch[i].ctl.els[0] : s_q.ch[i].ctl.els[0];
                end
            end
            // Coherent value load: at once for compare, at the period edge for PWM.
            if (s_d.ch[i].hi_wr && s_d.ch[i].lo_wr) begin
                if (oc || cap || (epwm && tick && !cnt_wr && s_d.cnt == `COUNT_ZERO) || (s_q.tsc.cpwm && wrap)) begin
                    s_d.ch[i].value = s_d.ch[i].wbuf;
                    s_d.ch[i].hi_wr = 1'b0;
                    s_d.ch[i].lo_wr = 1'b0;
                end
            end
            if (evt[i]) begin
                s_d.ch[i].ctl.flag = 1'b1;
                s_d.ch[i].clr_arm = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    for (genvar g = 0; g < NUM_CH; g++) begin : g_pin
        assign ch_pin_o[g] = s_q.ch[g].pin_out;
        assign ch_pin_oe_o[g] = !detached[g] && (s_q.tsc.cpwm || s_q.ch[g].ctl.msb || s_q.ch[g].ctl.msa);
        assign chan_irq_o[g] = s_q.ch[g].ctl.flag && s_q.ch[g].ctl.ie;
    end

    default clocking cb_main @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence count_read_s;
        ar_go && (s_axi_araddr == `ADDR_COUNT_HI) && !s_q.cnt_lat;
    endsequence

    sequence count_quiet_s;
        !ar_go && !cnt_wr;
    endsequence

    no_clock_idle_a: assert property ((s_q.tsc.clks == `CLKS_NONE) && !cnt_wr |=> $stable(s_q.cnt))
        else $error("Counter moved with no clock source.");
    debug_pause_a: assert property (debug_halt_i && !cnt_wr |=> $stable(s_q.cnt))
        else $error("Counter moved during debug halt.");
    up_wrap_a: assert property (tick && !cnt_wr && !s_q.tsc.cpwm && s_q.cnt == term |=> s_q.cnt == `COUNT_ZERO && s_q.tsc.counter_wrap_flag)
        else $error("Up counter did not wrap with flag.");
    down_turn_a: assert property (tick && !cnt_wr && s_q.tsc.cpwm && !s_q.dir_down && s_q.cnt == s_q.modulus && s_q.cnt != `COUNT_ZERO |=> s_q.dir_down && s_q.tsc.counter_wrap_flag && s_q.cnt == $past(s_q.cnt) - `COUNT_ONE)
        else $error("Up/down counter did not turn at modulus.");
    wrap_level_a: assert property (s_q.tsc.counter_wrap_flag && s_q.tsc.wrap_irq_enable |-> wrap_irq_o throughout (s_q.tsc.counter_wrap_flag && s_q.tsc.wrap_irq_enable)[*1])
        else $error("Wrap request missing while flag and enable set.");
    event_wins_a: assert property (evt[0] |=> s_q.ch[0].ctl.flag && !s_q.ch[0].clr_arm)
        else $error("Channel event lost against a clear.");
    detach_pin_a: assert property (s_q.ch[0].ctl.els == `ELS_OFF |-> !ch_pin_oe_o[0])
        else $error("Detached pin still driven.");
    count_clear_a: assert property (cnt_wr |=> s_q.cnt == `COUNT_ZERO && !s_q.cnt_lat)
        else $error("Count write did not zero the counter.");
    snap_hold_a: assert property (count_read_s ##1 count_quiet_s |=> s_q.cnt_lat && s_q.cnt_snap == $past(s_q.cnt_snap, 2))
        else $error("Count snapshot changed before second read.");
    endpoint_len_a: assert property (tick && s_q.tsc.cpwm && s_q.dir_down && s_q.cnt == `COUNT_ZERO && !cnt_wr |=> s_q.cnt == `COUNT_ONE && !s_q.dir_down)
        else $error("Zero endpoint did not last one tick.");

endmodule : timer_pwm

// ### verification/chan_pin_model.sv
// Far side of the channel pins: an outside source whose levels the bench requests.
// Assumes the bench requests levels only just after rising clock edges.
`timescale 1ns/1ns

module chan_pin_model #(
    parameter int NUM_CH = 2
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Requested levels and the block's pin drive
    input wire logic [NUM_CH-1:0] level_req_i,
    input wire logic [NUM_CH-1:0] drv_i,
    input wire logic [NUM_CH-1:0] oe_i,
    // Resolved pin levels
    output logic [NUM_CH-1:0] pin_o
);
    logic [NUM_CH-1:0] lvl_q;

    // Levels only move on clock edges, so each one stays steady for whole cycles.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= level_req_i;
        end
    end

    assign pin_o = (oe_i & drv_i) | (~oe_i & lvl_q);
endmodule : chan_pin_model

// ### verification/timer_pwm_bench.sv
// Self-checking bench of the timer/PWM block over AXI4-Lite.
// Assumes the map header constants and the pin partner model.
`timescale 1ns/1ns
`include "timer_pwm_map.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module timer_pwm_bench;
    localparam logic [7:0] C0 = `CH_BASE;
    localparam logic [7:0] C1 = `CH_BASE + `CH_STRIDE;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic halt = 1'b0;
    logic [1:0] lvl = 2'h0;
    logic [1:0] pin_i, pin_o, oe, cirq;
    logic wirq, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] q, q2;
    int bad_count = 0;
    int tests_run = 0;

    always #50 clk = ~clk;

    // The external clock stays idle, well inside the half-rate limit on its edges.
    timer_pwm timer_pwm_i (.ref_clk_i(clk), .resetn_i(rstn), .fixed_clk_en_i(1'b0), .ext_clk_i(1'b0),
        .debug_halt_i(halt), .ch_pin_i(pin_i), .ch_pin_o(pin_o), .ch_pin_oe_o(oe), .wrap_irq_o(wirq),
        .chan_irq_o(cirq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    chan_pin_model chan_pin_model_i (.ref_clk_i(clk), .resetn_i(rstn), .level_req_i(lvl),
        .drv_i(pin_o), .oe_i(oe), .pin_o(pin_i));

    // Handshakes are sampled at the rising edge itself, and released just after it.
    task automatic bus(input bit wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        bit acc, done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        if (wr) begin
            awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        end else begin
            araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        end
        while (!done) begin
            @(posedge clk);
            n++;
            acc = wr ? (awvalid && awready && wready) : (arvalid && arready);
            done = wr ? (bready && bvalid) : (rready && rvalid);
            q = rdata[7:0];
            rs = wr ? bresp : rresp;
            if (acc) begin awvalid <= 1'b0; wvalid <= 1'b0; arvalid <= 1'b0; end
            if (done) begin bready <= 1'b0; rready <= 1'b0; end
            if (n > 40) begin bad_count++; $display("[ERR] bus timeout"); end_sim(); end
        end
    endtask : bus

    task automatic w(input logic [7:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask : w
    task automatic r(input logic [7:0] a); bus(1'b0, a, 8'h00); endtask : r

    task automatic t_reset;
        r(`ADDR_TIMER_SC); `CHK("timer ctl", 8'h00, q)
        r(C0 + `CH_OFF_LO); `CHK("ch0 value", 8'h00, q)
        r(8'hfc); `CHK("unmapped resp", `RESP_SLVERR, rs)
        repeat (5) @(posedge clk);
        r(`ADDR_COUNT_LO); `CHK("idle count", 8'h00, q)
        r(`ADDR_COUNT_HI);
    endtask : t_reset

    task automatic t_wrap;
        w(`ADDR_MOD_HI, 8'h00);
        w(`ADDR_MOD_LO, 8'h09); `CHK("mod write resp", `RESP_OKAY, rs)
        w(`ADDR_TIMER_SC, 8'h48);
        repeat (25) @(posedge clk);
        @(negedge clk); `CHK("wrap irq", 1'b1, wirq)
        r(`ADDR_COUNT_LO); q2 = q;
        r(`ADDR_COUNT_HI); `CHK("count hi", 8'h00, q)
        `CHK("count in range", 1'b1, q2 <= 8'h09)
        r(`ADDR_TIMER_SC); `CHK("wrap flag", 8'hc8, q)
        w(`ADDR_TIMER_SC, 8'h08);
        @(negedge clk); `CHK("irq masked", 1'b0, wirq)
    endtask : t_wrap

    task automatic t_halt;
        halt <= 1'b1;
        w(`ADDR_COUNT_LO, 8'h5a);
        repeat (4) @(posedge clk);
        r(`ADDR_COUNT_LO); q2 = q;
        r(`ADDR_COUNT_HI); `CHK("count hi", 8'h00, q)
        `CHK("count lo", 8'h00, q2)
        halt <= 1'b0;
    endtask : t_halt

    task automatic t_capture;
        w(C0, 8'h44);
        repeat (3) @(posedge clk);
        @(negedge clk); `CHK("no false edge", 1'b0, cirq[0])
        @(posedge clk); lvl[0] <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk); `CHK("rise capture", 1'b1, cirq[0])
        r(C0); `CHK("ch0 flag", 8'hc4, q)
        w(C0, 8'h44);
        @(negedge clk); `CHK("flag cleared", 1'b0, cirq[0])
        @(posedge clk); lvl[0] <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk); `CHK("fall ignored", 1'b0, cirq[0])
    endtask : t_capture

    task automatic t_compare;
        w(C1 + `CH_OFF_HI, 8'h00);
        w(C1 + `CH_OFF_LO, 8'h05);
        w(C1, 8'h1c);
        w(C0, 8'h10);
        repeat (15) @(posedge clk);
        @(negedge clk); `CHK("set on match", 1'b1, pin_o[1])
        `CHK("ch1 drives", 1'b1, oe[1])
        `CHK("ch0 pin free", 1'b0, oe[0])
        r(C0); `CHK("soft compare", 1'b1, q[7])
    endtask : t_compare

    task automatic end_sim;
        $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_wrap();
        t_halt();
        t_capture();
        t_compare();
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        end_sim();
    end
endmodule : timer_pwm_bench
